// *** design/host_bus_defs.svh ***
`ifndef HOST_BUS_DEFS_SVH
`define HOST_BUS_DEFS_SVH

// Synchronous mode pin levels
`define SYNC_MODE_SINGLE 1'b0
`define SYNC_MODE_BURST 1'b1
// Single-cycle write/read level meaning write
`define SWR_WRITE_LEVEL 1'b1
// Idle levels of ready outputs
`define ASYNC_WAIT_READY_RESET 1'b1
`define SRDY_RESET 1'b1
// Decode field positions
`define DECODE_MSB 15
`define DECODE_LSB 4
`define WORD_SWAP_BIT 1
// Byte enables forced by the data port select
`define DATA_PORT_BE 4'hF
`define DATA_RESET 32'h0000_0000

`endif

// *** design/host_bus_pkg.sv ***
package host_bus_pkg;

  // Core-domain sequencer states
  typedef enum logic [5:0] {
    C_IDLE = 6'b000001,
    C_RD_WAIT = 6'b000010,
    C_RD_HOLD = 6'b000100,
    C_WR_HOLD = 6'b001000,
    C_BUSY = 6'b010000,
    C_SYNC = 6'b100000
  } core_state_e;

  // Link-domain sequencer states
  typedef enum logic [2:0] {
    L_IDLE = 3'b001,
    L_WAIT = 3'b010,
    L_DONE = 3'b100
  } link_state_e;

endpackage : host_bus_pkg

// *** design/host_bus_unit.sv ***
`timescale 1ns/1ps
`include "host_bus_defs.svh"

// Three-stage input synchroniser; a change counts once stages two and three agree
module input_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  // Stage chain and agreement filter
  always_ff @(posedge clock) begin
    if (!resetn) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      dout <= INIT;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= (s2 & s3) | (dout & (s2 ^ s3));
    end
  end
endmodule : input_sync

// What this block does
// - Every async transfer is a single data transfer; no bursts.
// - Address, enable, byte enables latch: transparent while strobe low, hold on rise.
// - Local select is a combinational decode of A15..A4 with enable versus base.
// - Sixteen I/O locations decoded from A15..A4 plus address enable.
// - Write data taken at write strobe rise; host takes read data at read rise.
// - 32-bit bus data port select bypasses decode, forces 32 bits, ignores enables.
// - Async ready goes to wait at the strobe's leading edge when time needed; here it drops only once the synchronised strobe is seen, on every hit.
// - Async ready low requests wait; high lets the transfer complete.
// - Mode pin 0 selects single-cycle operation, 1 selects burst operation.
// - Single-cycle mode does single transfers via local decode, no bursts.
// - Single-cycle mode samples write/read on bus clock while qualifier asserted.
// - Single-cycle mode: write/read high means write, low means read.
// - Single-cycle ends with sync ready; read data held until ready-return.
// - In burst either side stretches: host by ready-return, device by sync ready.
// - Burst transfers use sync signals with the data port select, mode pin 1.
// - 8-bit bus: upper lane enable is inverse of lower lane enable.
// - Byte, word, dword access; word swap inside, never byte swap.
module host_bus_unit #(
  parameter int BUS_WIDTH = 32
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic bus_clock,
  input wire logic bus_resetn,
  input wire logic [11:0] base_addr,
  input wire logic [15:1] addr,
  input wire logic addr_qualify_enable,
  input wire logic addr_strobe_n,
  input wire logic byte_lane0_enable_n,
  input wire logic byte_lane1_enable_n,
  input wire logic byte_lane2_enable_n,
  input wire logic byte_lane3_enable_n,
  input wire logic data_port_select_n,
  input wire logic async_read_strobe_n,
  input wire logic async_write_strobe_n,
  input wire logic sync_mode_select,
  input wire logic sync_cycle_qualifier_n,
  input wire logic sync_write_read,
  input wire logic host_ready_return_n,
  input wire logic [31:0] host_data_in,
  output logic local_select_n,
  output logic async_wait_ready,
  output logic [31:0] async_data_out,
  output logic async_data_oe,
  output logic dev_sync_ready_n,
  output logic [31:0] sync_data_out,
  output logic sync_data_oe,
  output logic int_req,
  output logic int_write,
  output logic [2:0] int_word,
  output logic [3:0] int_be,
  output logic int_data_port,
  output logic [31:0] int_wdata,
  input wire logic int_ack,
  input wire logic [31:0] int_rdata
);

  generate
    if (BUS_WIDTH != 8 && BUS_WIDTH != 16 && BUS_WIDTH != 32) begin : g_bad_width
      $error("BUS_WIDTH must be 8, 16 or 32");
    end
  endgenerate

  localparam bit NARROW = (BUS_WIDTH != 32);
  localparam bit WIDE = (BUS_WIDTH == 32);

  // Active-high byte lanes after width, swap and data-port handling
  function automatic logic [3:0] lanes(input logic [3:0] be_n, input logic hi, input logic dsel);
    logic [3:0] b;
    b = ~be_n;
    if (BUS_WIDTH == 8) begin
      b = {2'b00, be_n[0], ~be_n[0]};
    end
    if (NARROW && hi) begin
      b = {b[1:0], 2'b00};
    end
    if (dsel) begin
      b = `DATA_PORT_BE;
    end
    return b;
  endfunction : lanes

  // Narrow bus: lower half copied up when the upper word is addressed
  function automatic logic [31:0] swap_in(input logic [31:0] d, input logic hi);
    return (NARROW && hi) ? {d[15:0], d[15:0]} : d;
  endfunction : swap_in

  // Narrow bus: upper word brought down to the lower lanes, bytes kept in place
  function automatic logic [31:0] swap_out(input logic [31:0] d, input logic hi);
    return (NARROW && hi) ? {d[31:16], d[31:16]} : d;
  endfunction : swap_out

  // Address latch, transparent while the strobe is low
  logic [15:1] lat_addr;
  logic lat_aen;
  logic [3:0] lat_be_n;
  always_latch begin
    if (!addr_strobe_n) begin
      lat_addr = addr;
      lat_aen = addr_qualify_enable;
      lat_be_n = {byte_lane3_enable_n, byte_lane2_enable_n, byte_lane1_enable_n, byte_lane0_enable_n};
    end
  end

  // Local decode over sixteen locations, data port select overrides it
  wire decode_hit = lat_aen && (lat_addr[`DECODE_MSB:`DECODE_LSB] == base_addr);
  wire data_sel = WIDE && !data_port_select_n;
  wire target = data_sel || decode_hit;
  wire word_hi = lat_addr[`WORD_SWAP_BIT];
  wire [3:0] pin_lanes = lanes(lat_be_n, word_hi, data_sel);
  assign local_select_n = !(decode_hit && !data_sel);

  // ---------------- Link domain (bus clock) ----------------
  host_bus_pkg::link_state_e lstate;
  logic req_tog;
  logic l_write;
  logic [2:0] l_word;
  logic [3:0] l_be;
  logic l_dsel;
  logic l_hi;
  logic [31:0] l_wdata;
  logic cyc_prev_n;
  logic done_seen;
  logic done_sync;
  logic done_tog;
  logic [31:0] x_rdata;

  input_sync #(.W(1), .INIT(1'b0)) u_done_sync (
    .clock(bus_clock),
    .resetn(bus_resetn),
    .din(done_tog),
    .dout(done_sync)
  );

  // Mode selection and start conditions
  wire burst_mode = (sync_mode_select == `SYNC_MODE_BURST);
  wire single_start = !burst_mode && target && !sync_cycle_qualifier_n && cyc_prev_n;
  wire burst_cmd = burst_mode && data_sel && (!sync_write_read || !sync_cycle_qualifier_n);
  wire link_start = single_start || burst_cmd;
  wire start_write = burst_mode ? !sync_cycle_qualifier_n : (sync_write_read == `SWR_WRITE_LEVEL);
  wire link_done = (done_sync != done_seen);
  wire host_ends = burst_mode ? host_ready_return_n : !host_ready_return_n;

  // Qualifier history for single-cycle edge detection
  always_ff @(posedge bus_clock) begin
    if (!bus_resetn) begin
      cyc_prev_n <= 1'b1;
    end else begin
      cyc_prev_n <= sync_cycle_qualifier_n;
    end
  end

  // Request fields, held steady while the core serves them
  always_ff @(posedge bus_clock) begin
    if (!bus_resetn) begin
      req_tog <= 1'b0;
      l_write <= 1'b0;
      l_word <= 3'h0;
      l_be <= 4'h0;
      l_dsel <= 1'b0;
      l_hi <= 1'b0;
      l_wdata <= `DATA_RESET;
    end else if (lstate == host_bus_pkg::L_IDLE && link_start) begin
      req_tog <= !req_tog;
      l_write <= start_write;
      l_word <= lat_addr[3:1];
      l_be <= pin_lanes;
      l_dsel <= data_sel;
      l_hi <= word_hi;
      l_wdata <= swap_in(host_data_in, word_hi);
    end
  end

  // Link sequencer: request, answer with ready, wait for host
  always_ff @(posedge bus_clock) begin
    if (!bus_resetn) begin
      lstate <= host_bus_pkg::L_IDLE;
      done_seen <= 1'b0;
      dev_sync_ready_n <= `SRDY_RESET;
      sync_data_oe <= 1'b0;
      sync_data_out <= `DATA_RESET;
    end else begin
      unique case (lstate)
        host_bus_pkg::L_IDLE: begin
          sync_data_oe <= 1'b0;
          if (link_start) begin
            dev_sync_ready_n <= !burst_mode;
            lstate <= host_bus_pkg::L_WAIT;
          end else begin
            dev_sync_ready_n <= `SRDY_RESET;
          end
        end
        host_bus_pkg::L_WAIT: begin
          if (link_done) begin
            done_seen <= done_sync;
            dev_sync_ready_n <= burst_mode;
            sync_data_oe <= !l_write;
            sync_data_out <= swap_out(x_rdata, l_hi);
            lstate <= host_bus_pkg::L_DONE;
          end
        end
        host_bus_pkg::L_DONE: begin
          if (host_ends) begin
            dev_sync_ready_n <= `SRDY_RESET;
            sync_data_oe <= 1'b0;
            lstate <= host_bus_pkg::L_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------- Core domain ----------------
  host_bus_pkg::core_state_e cstate;
  logic [43:0] pin_sync;
  logic req_sync;
  logic req_seen;
  logic [31:0] wr_hold;

  input_sync #(.W(44), .INIT({2'b11, 42'h0})) u_pin_sync (
    .clock(clock),
    .resetn(resetn),
    .din({async_read_strobe_n, async_write_strobe_n, target, data_sel, word_hi, lat_addr[3:1],
          pin_lanes, host_data_in}),
    .dout(pin_sync)
  );

  input_sync #(.W(1), .INIT(1'b0)) u_req_sync (
    .clock(clock),
    .resetn(resetn),
    .din(req_tog),
    .dout(req_sync)
  );

  // Synchronised pin fields
  wire rd_act = !pin_sync[43];
  wire wr_act = !pin_sync[42];
  wire s_target = pin_sync[41];
  wire s_dsel = pin_sync[40];
  wire s_hi = pin_sync[39];
  wire [2:0] s_word = pin_sync[38:36];
  wire [3:0] s_lanes = pin_sync[35:32] | {4{s_dsel}};
  wire [31:0] s_data = swap_in(pin_sync[31:0], s_hi);
  wire async_go = s_target && (rd_act || wr_act);
  wire link_req = (req_sync != req_seen);

  // Core sequencer: async transfers and link requests, one at a time
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cstate <= host_bus_pkg::C_IDLE;
      async_wait_ready <= `ASYNC_WAIT_READY_RESET;
      async_data_oe <= 1'b0;
      async_data_out <= `DATA_RESET;
      req_seen <= 1'b0;
      done_tog <= 1'b0;
      x_rdata <= `DATA_RESET;
      wr_hold <= `DATA_RESET;
      int_req <= 1'b0;
      int_write <= 1'b0;
      int_word <= 3'h0;
      int_be <= 4'h0;
      int_data_port <= 1'b0;
      int_wdata <= `DATA_RESET;
    end else begin
      int_req <= 1'b0;
      unique case (cstate)
        host_bus_pkg::C_IDLE: begin
          if (async_go) begin
            async_wait_ready <= 1'b0;
            int_word <= s_word;
            int_be <= s_lanes;
            int_data_port <= s_dsel;
            if (rd_act) begin
              int_req <= 1'b1;
              int_write <= 1'b0;
              cstate <= host_bus_pkg::C_RD_WAIT;
            end else begin
              cstate <= host_bus_pkg::C_WR_HOLD;
            end
          end else if (link_req) begin
            req_seen <= req_sync;
            int_req <= 1'b1;
            int_write <= l_write;
            int_word <= l_word;
            int_be <= l_be;
            int_data_port <= l_dsel;
            int_wdata <= l_wdata;
            cstate <= host_bus_pkg::C_SYNC;
          end
        end
        host_bus_pkg::C_RD_WAIT: begin
          if (int_ack) begin
            async_data_out <= swap_out(int_rdata, s_hi);
            async_data_oe <= 1'b1;
            async_wait_ready <= 1'b1;
            cstate <= host_bus_pkg::C_RD_HOLD;
          end
        end
        host_bus_pkg::C_RD_HOLD: begin
          if (!rd_act) begin
            async_data_oe <= 1'b0;
            cstate <= host_bus_pkg::C_IDLE;
          end
        end
        host_bus_pkg::C_WR_HOLD: begin
          async_wait_ready <= 1'b1;
          if (wr_act) begin
            wr_hold <= s_data;
          end else begin
            int_req <= 1'b1;
            int_write <= 1'b1;
            int_wdata <= wr_hold;
            cstate <= host_bus_pkg::C_BUSY;
          end
        end
        host_bus_pkg::C_BUSY: begin
          async_wait_ready <= !async_go;
          if (int_ack) begin
            cstate <= host_bus_pkg::C_IDLE;
          end
        end
        host_bus_pkg::C_SYNC: begin
          if (int_ack) begin
            x_rdata <= int_rdata;
            done_tog <= !done_tog;
            cstate <= host_bus_pkg::C_IDLE;
          end
        end
      endcase
    end
  end

endmodule : host_bus_unit

// *** sim/reg_side_model.sv ***
`timescale 1ns/1ps
// Register side: answers each request after lat cycles
module reg_side_model (
  input wire logic clock,
  input wire logic int_req,
  input wire logic [2:0] int_word,
  input wire logic [3:0] lat,
  output logic int_ack,
  output logic [31:0] int_rdata
);
  logic [3:0] cnt = 4'h0;
  initial int_ack = 1'b0;
  initial int_rdata = 32'h0;
  // Delay count, one-cycle ack, data scrambled outside the ack
  always @(posedge clock) begin
    int_ack <= cnt == 4'h1;
    int_rdata <= (cnt == 4'h1) ? {16'hC0DE, 13'h0, int_word} : ~int_rdata;
    cnt <= int_req ? lat : (cnt != 4'h0) ? cnt - 4'h1 : cnt;
  end
endmodule : reg_side_model

// *** sim/host_bus_unit_chk.sv ***
`timescale 1ns/1ps
// Port checks of the host bus unit
module host_bus_chk (
  input wire logic clock,
  input wire logic resetn,
  input wire logic bus_clock,
  input wire logic bus_resetn,
  input wire logic [11:0] base_addr,
  input wire logic [15:1] addr,
  input wire logic addr_qualify_enable,
  input wire logic addr_strobe_n,
  input wire logic data_port_select_n,
  input wire logic async_read_strobe_n,
  input wire logic sync_mode_select,
  input wire logic host_ready_return_n,
  input wire logic local_select_n,
  input wire logic async_wait_ready,
  input wire logic async_data_oe,
  input wire logic dev_sync_ready_n,
  input wire logic [31:0] sync_data_out,
  input wire logic sync_data_oe,
  input wire logic int_req,
  input wire logic [3:0] int_be,
  input wire logic int_data_port
);
  // Core domain
  property p_lsel;
    @(posedge clock) disable iff (!resetn)
    !addr_strobe_n |-> local_select_n == !(addr_qualify_enable && addr[15:4] == base_addr && data_port_select_n);
  endproperty
  a_lsel: assert property (p_lsel) else $error("bad select decode");
  property p_miss;
    @(posedge clock) disable iff (!resetn)
    (!async_read_strobe_n && local_select_n && data_port_select_n)[*8] |-> async_wait_ready && !async_data_oe;
  endproperty
  a_miss: assert property (p_miss) else $error("answered a miss");
  property p_wait;
    @(posedge clock) disable iff (!resetn)
    $fell(async_read_strobe_n) && !local_select_n |-> ##[1:8] !async_wait_ready;
  endproperty
  a_wait: assert property (p_wait) else $error("no wait on read");
  property p_rdy_oe;
    @(posedge clock) disable iff (!resetn)
    $rose(async_wait_ready) && !async_read_strobe_n |-> async_data_oe;
  endproperty
  a_rdy_oe: assert property (p_rdy_oe) else $error("ready without data");
  property p_oe_off;
    @(posedge clock) disable iff (!resetn)
    $rose(async_read_strobe_n) |-> ##[1:8] !async_data_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("read drive stuck");
  property p_dp;
    @(posedge clock) disable iff (!resetn)
    int_req && int_data_port |-> int_be == 4'hF && !data_port_select_n;
  endproperty
  a_dp: assert property (p_dp) else $error("data port lanes");
  // Bus clock domain
  property p_shold;
    @(posedge bus_clock) disable iff (!bus_resetn)
    !sync_mode_select && !dev_sync_ready_n && host_ready_return_n |=> !dev_sync_ready_n && $stable(sync_data_out);
  endproperty
  a_shold: assert property (p_shold) else $error("ready dropped early");
  property p_srel;
    @(posedge bus_clock) disable iff (!bus_resetn)
    !sync_mode_select && !dev_sync_ready_n && !host_ready_return_n |=> dev_sync_ready_n && !sync_data_oe;
  endproperty
  a_srel: assert property (p_srel) else $error("ready not released");
  property p_bhold;
    @(posedge bus_clock) disable iff (!bus_resetn)
    sync_mode_select && sync_data_oe && !host_ready_return_n |=> sync_data_oe && $stable(sync_data_out);
  endproperty
  a_bhold: assert property (p_bhold) else $error("beat not held");
  c_ard: cover property (@(posedge clock) $rose(async_data_oe));
  c_sync: cover property (@(posedge bus_clock) !sync_mode_select && !dev_sync_ready_n);
  c_burst: cover property (@(posedge bus_clock) sync_mode_select && sync_data_oe && !host_ready_return_n);
endmodule : host_bus_chk
bind host_bus_unit host_bus_chk chk_u (.*);

// *** sim/host_bus_unit_tb.sv ***
`timescale 1ns/1ps
module host_bus_unit_tb;
  logic clock = 1'b0, bus_clock = 1'b0, resetn = 1'b0, bus_resetn = 1'b0;
  logic [11:0] base_addr = 12'h030;
  logic [15:1] addr = 15'h0;
  logic addr_qualify_enable = 1'b1, addr_strobe_n = 1'b0;
  logic byte_lane0_enable_n = 1'b0, byte_lane1_enable_n = 1'b0;
  logic byte_lane2_enable_n = 1'b1, byte_lane3_enable_n = 1'b1;
  logic data_port_select_n = 1'b1, async_read_strobe_n = 1'b1, async_write_strobe_n = 1'b1;
  logic sync_mode_select = 1'b0, sync_cycle_qualifier_n = 1'b1, sync_write_read = 1'b1;
  logic host_ready_return_n = 1'b1, m_wr, m_dp;
  logic [31:0] host_data_in = 32'h0, async_data_out, sync_data_out, int_wdata, int_rdata, m_wd;
  logic local_select_n, async_wait_ready, async_data_oe, dev_sync_ready_n, sync_data_oe;
  logic int_req, int_write, int_data_port, int_ack;
  logic [2:0] int_word;
  logic [3:0] int_be, m_be, lat = 4'h1;
  int n_req = 0, num_errors = 0, comparisons = 0;
  // Wait bound, wide enough for a full crossing with slow register answers
  localparam int LIMIT = 200;

  host_bus_unit #(.BUS_WIDTH(32)) dut_u (.*);
  reg_side_model rsm_u (.clock, .int_req, .int_word, .lat, .int_ack, .int_rdata);

  always #10 clock = ~clock;
  initial begin
    #1.3;
    forever #3 bus_clock = ~bus_clock;
  end
  // Captures each internal request
  always @(posedge clock) begin
    if (int_req === 1'b1) begin
      n_req <= n_req + 1;
      {m_wr, m_dp, m_be, m_wd} <= {int_write, int_data_port, int_be, int_wdata};
    end
  end

  function automatic logic [31:0] exp_rd(input logic [2:0] w);
    return {16'hC0DE, 13'h0, w};
  endfunction : exp_rd

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  task automatic bound(input int i);
    if (i >= LIMIT) begin
      num_errors++;
      test_done();
    end
  endtask : bound

  task automatic t_miss;
    int i;
    addr = {12'h030, 3'h0};
    @(negedge clock);
    addr_strobe_n = 1'b1;
    @(negedge clock);
    addr = {12'h031, 3'h0};
    @(negedge clock);
    check("latched", local_select_n, 1'b0);
    addr_strobe_n = 1'b0;
    @(negedge clock);
    check("lsel miss", local_select_n, 1'b1);
    async_read_strobe_n = 1'b0;
    for (i = 0; i < 12; i++) begin
      @(negedge clock);
      check("idle", {async_wait_ready, async_data_oe}, 2'b10);
    end
    async_read_strobe_n = 1'b1;
    $display("end miss");
  endtask : t_miss

  task automatic t_async_rd(input logic [2:0] w, input logic [3:0] l, input logic dp);
    int i;
    lat = l;
    addr = {dp ? 12'h031 : 12'h030, w};
    data_port_select_n = !dp;
    addr_qualify_enable = !dp;
    @(negedge clock);
    check("lsel", local_select_n, dp);
    async_read_strobe_n = 1'b0;
    for (i = 0; i < LIMIT && async_wait_ready !== 1'b0; i++) @(negedge clock);
    bound(i);
    for (i = 0; i < LIMIT && async_wait_ready !== 1'b1; i++) @(negedge clock);
    bound(i);
    check("rdata", async_data_out, exp_rd(w));
    check("rreq", {m_wr, m_dp, m_be}, {1'b0, dp, dp ? 4'hF : 4'h3});
    async_read_strobe_n = 1'b1;
    for (i = 0; i < LIMIT && async_data_oe !== 1'b0; i++) @(negedge clock);
    bound(i);
    data_port_select_n = 1'b1;
    addr_qualify_enable = 1'b1;
    $display("end async read");
  endtask : t_async_rd

  task automatic t_async_wr(input logic [2:0] w);
    int i;
    int n;
    n = n_req;
    addr = {12'h030, w};
    host_data_in = 32'h1234_5678;
    {byte_lane3_enable_n, byte_lane2_enable_n, byte_lane1_enable_n, byte_lane0_enable_n} = 4'h3;
    async_write_strobe_n = 1'b0;
    repeat (8) @(negedge clock);
    async_write_strobe_n = 1'b1;
    host_data_in = 32'hEDCB_A987;
    for (i = 0; i < LIMIT && n_req == n; i++) @(negedge clock);
    bound(i);
    check("wreq", {m_wr, m_dp, m_be}, {1'b1, 1'b0, 4'hC});
    check("wdata", m_wd, 32'h1234_5678);
    {byte_lane3_enable_n, byte_lane2_enable_n, byte_lane1_enable_n, byte_lane0_enable_n} = 4'hC;
    repeat (6) @(negedge clock);
    $display("end async write");
  endtask : t_async_wr

  task automatic t_sync(input logic wr, input logic [2:0] w);
    int i;
    addr = {12'h030, w};
    host_data_in = {16'hBEEF, 13'h0, w};
    @(negedge bus_clock);
    sync_write_read = wr;
    sync_cycle_qualifier_n = 1'b0;
    for (i = 0; i < LIMIT && dev_sync_ready_n !== 1'b0; i++) @(negedge bus_clock);
    bound(i);
    repeat (2) @(negedge bus_clock);
    check("sready", dev_sync_ready_n, 1'b0);
    if (!wr) check("sdata", sync_data_out, exp_rd(w));
    check("sreq", {m_wr, m_dp, m_be}, {wr, 1'b0, 4'h3});
    if (wr) check("swdata", m_wd, {16'hBEEF, 13'h0, w});
    host_ready_return_n = 1'b0;
    sync_cycle_qualifier_n = 1'b1;
    sync_write_read = 1'b1;
    @(negedge bus_clock);
    host_ready_return_n = 1'b1;
    @(negedge bus_clock);
    check("srel", dev_sync_ready_n, 1'b1);
    $display("end sync single");
  endtask : t_sync

  task automatic t_burst(input logic wr);
    int i;
    sync_mode_select = 1'b1;
    data_port_select_n = 1'b0;
    addr_qualify_enable = 1'b0;
    addr = 15'h0;
    host_data_in = 32'h0F1E_2D3C;
    @(negedge bus_clock);
    if (wr) sync_cycle_qualifier_n = 1'b0;
    else sync_write_read = 1'b0;
    for (i = 0; i < LIMIT && dev_sync_ready_n !== 1'b0; i++) @(negedge bus_clock);
    bound(i);
    for (i = 0; i < LIMIT && dev_sync_ready_n !== 1'b1; i++) @(negedge bus_clock);
    bound(i);
    host_ready_return_n = 1'b0;
    repeat (2) @(negedge bus_clock);
    if (!wr) check("bdata", sync_data_out, exp_rd(3'h0));
    check("breq", {m_wr, m_dp, m_be}, {wr, 1'b1, 4'hF});
    if (wr) check("bwdata", m_wd, 32'h0F1E_2D3C);
    host_ready_return_n = 1'b1;
    @(negedge bus_clock);
    {sync_write_read, sync_cycle_qualifier_n, data_port_select_n} = 3'h7;
    host_data_in = 32'hF0E1_D2C3;
    repeat (8) @(negedge bus_clock);
    $display("end burst");
  endtask : t_burst

  initial begin
    repeat (12) @(negedge clock);
    resetn = 1'b1;
    bus_resetn = 1'b1;
    repeat (6) @(negedge clock);
    t_miss();
    t_async_rd(3'h4, 4'h1, 1'b0);
    t_async_rd(3'h0, 4'h9, 1'b1);
    t_async_wr(3'h2);
    t_sync(1'b0, 3'h6);
    t_sync(1'b1, 3'h2);
    t_burst(1'b0);
    t_burst(1'b1);
    test_done();
  end
endmodule : host_bus_unit_tb
